// File: code_checker.sv
// Request code parameter check and defaulting
`timescale 1ns/10ps
`default_nettype none
`include "srq_gen_cfg.svh"

module code_checker (
    input  wire logic       code_present,
    input  wire logic [7:0] code_value,
    output logic            code_ok,
    output logic [4:0]      code_eff
);
    // Missing code becomes zero, above range refused
    always_comb begin
        code_ok  = 1'b1;
        code_eff = `CODE_DEFAULT;
        if (code_present) begin
            code_ok  = (code_value <= `CODE_MAX);
            code_eff = code_value[4:0];
        end
    end
endmodule : code_checker
`default_nettype wire

// File: host_poll_model.sv
// Host controller that serially polls after a service request
`timescale 1ns/10ps
`default_nettype none
module host_poll_model (
    input wire logic       ref_clk,
    input wire logic       srq_out,
    input wire logic [3:0] hold,
    output var logic       poll_done
);
    // Poll after a chosen delay, one-cycle completion pulse
    initial begin
        poll_done = 1'b0;
        forever begin
            @(negedge ref_clk);
            poll_done = 1'b0;
            if (srq_out) begin
                repeat (hold) @(negedge ref_clk);
                poll_done = 1'b1;
            end
        end
    end
endmodule : host_poll_model
`default_nettype wire

// File: host_service_request_generator.sv
// Service request command handler with serial poll status byte
`timescale 1ns/10ps
`default_nettype none
`include "srq_gen_cfg.svh"

// Notes on behaviour
// - Executing command with a code in range or missing asserts service request line
// - Poll byte bit 6 set for request
// - Request code in low five bits
// - Codes 0..31, missing is 0, else error 7
// - Request raised only when command executes
module host_service_request_generator (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       cmd_exec,
    input  wire logic       code_present,
    input  wire logic [7:0] code_value,
    input  wire logic       poll_done,
    output logic            srq_out,
    output logic [7:0]      status_byte,
    output logic            cmd_done,
    output logic            err_valid,
    output logic [7:0]      err_code
);
    // ****************************************
    // Declarations
    // ****************************************
    // Parameter check results
    logic                    code_ok;   // Code in range or missing
    logic [4:0]              code_eff;  // Code after defaulting

    // Strobes of this cycle
    logic                    cmd_take;  // Command accepted
    logic                    cmd_bad;   // Command refused
    logic                    poll_take; // Poll that withdraws a request

    // Request state and line
    srq_gen_pkg::srq_state_t state_q;
    srq_gen_pkg::srq_state_t state_d;
    logic                    srq_q;
    logic                    srq_d;

    // Status byte
    logic [7:0]              stb_new;   // Byte for a fresh command
    logic [7:0]              stb_q;
    logic [7:0]              stb_d;

    // Error report and completion
    logic                    errv_q;
    logic                    errv_d;
    logic [7:0]              err_q;
    logic [7:0]              err_d;
    logic                    done_q;
    logic                    done_d;

    // ****************************************
    // Parameter check
    // ****************************************
    // Range check and default for the code
    code_checker u_check (
        .code_present (code_present),
        .code_value   (code_value),
        .code_ok      (code_ok),
        .code_eff     (code_eff)
    );

    // ****************************************
    // Command decode
    // ****************************************
    // Sort the strobes of this cycle
    always_comb begin
        cmd_take  = cmd_exec && code_ok;
        cmd_bad   = cmd_exec && !code_ok;
        poll_take = poll_done && srq_q;
    end

    // ****************************************
    // Status byte image
    // ****************************************
    // One pass per bit of the new byte
    for (genvar b = 0; b < 8; b++) begin : g_stb_bit
        if (b == `STB_RQS_BIT) begin : g_rqs
            assign stb_new[b] = 1'b1;
        end else if (b < `STB_CODE_W) begin : g_code
            assign stb_new[b] = code_eff[b];
        end else begin : g_zero
            assign stb_new[b] = 1'b0;
        end
    end

    // ****************************************
    // Request state
    // ****************************************
    // Next state and request line
    always_comb begin
        // Hold in idle and pending unless a strobe moves it
        state_d = state_q;
        case (state_q)
            srq_gen_pkg::ST_IDLE: begin
                // Wait for an accepted command
                if (cmd_take) begin
                    state_d = srq_gen_pkg::ST_PENDING;
                end
            end
            srq_gen_pkg::ST_PENDING: begin
                // A new command keeps the request up
                if (!cmd_take && poll_take) begin
                    state_d = srq_gen_pkg::ST_POLLED;
                end
            end
            srq_gen_pkg::ST_POLLED: begin
                // Poll just finished, line already low
                if (cmd_take) begin
                    state_d = srq_gen_pkg::ST_PENDING;
                end else begin
                    state_d = srq_gen_pkg::ST_IDLE;
                end
            end
            default: begin
                // Unused code falls back to idle
                state_d = srq_gen_pkg::ST_IDLE;
            end
        endcase
        // Line high only while a request waits
        srq_d = (state_d == srq_gen_pkg::ST_PENDING);
    end

    // ****************************************
    // Request registers
    // ****************************************
    // Request state and line
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= srq_gen_pkg::ST_IDLE;
            srq_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            srq_q   <= srq_d;
        end
    end

    // ****************************************
    // Status byte
    // ****************************************
    // New command wins over a same-cycle poll
    always_comb begin
        stb_d = stb_q;
        if (cmd_take) begin
            stb_d = stb_new;
        end else if (poll_take) begin
            // Completed poll empties the byte
            stb_d = `STB_RESET;
        end
    end

    // Status byte register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stb_q <= `STB_RESET;
        end else begin
            stb_q <= stb_d;
        end
    end

    // ****************************************
    // Error report
    // ****************************************
    // Error pulse and held error number
    always_comb begin
        errv_d = 1'b0;
        err_d  = err_q;
        if (cmd_bad) begin
            errv_d = 1'b1;
            err_d  = `ERR_RANGE;
        end else if (cmd_take) begin
            // Accepted command clears the number
            err_d  = `ERR_NONE;
        end
    end

    // Error registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            errv_q <= 1'b0;
            err_q  <= `ERR_NONE;
        end else begin
            errv_q <= errv_d;
            err_q  <= err_d;
        end
    end

    // ****************************************
    // Command completion
    // ****************************************
    // One pulse per command, taken or refused
    always_comb begin
        done_d = cmd_exec;
    end

    // Completion register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Request line and status byte
    assign srq_out     = srq_q;
    assign status_byte = stb_q;

    // Completion and error report
    assign cmd_done    = done_q;
    assign err_valid   = errv_q;
    assign err_code    = err_q;
endmodule : host_service_request_generator
`default_nettype wire

// File: host_service_request_generator_tb.sv
// Self-checking bench for the service request generator
`timescale 1ns/10ps
`default_nettype none
module host_service_request_generator_tb;
    logic ref_clk = 0, rst_n = 0, cmd_exec = 0, code_present = 0;
    logic poll_done, srq_out, cmd_done, err_valid;
    logic [7:0] code_value = 8'h00, status_byte, err_code;
    logic [3:0] hold = 4'h3;
    int num_errors = 0, comparisons = 0, cyc = 0;
    // Rows: present, code, expected status byte
    logic [16:0] rows [6] = '{17'h1_0343, 17'h0_0940, 17'h1_1F5F, 17'h1_0040, 17'h1_2000,
        17'h1_FF00};
    host_service_request_generator dut (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .cmd_exec     (cmd_exec),
        .code_present (code_present),
        .code_value   (code_value),
        .poll_done    (poll_done),
        .srq_out      (srq_out),
        .status_byte  (status_byte),
        .cmd_done     (cmd_done),
        .err_valid    (err_valid),
        .err_code     (err_code)
    );
    host_poll_model host (.ref_clk, .srq_out, .hold, .poll_done);
    task automatic chk(input string what, input logic [7:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (++cyc > 2000) begin
        num_errors++;
        wrap_up();
    end
    // Table rows, then back-to-back error and reset
    initial begin
        repeat (10) @(negedge ref_clk);
        rst_n = 1;
        foreach (rows[i]) begin
            {code_present, code_value} = rows[i][16:8];
            cmd_exec = 1;
            @(negedge ref_clk);
            cmd_exec = 0;
            chk("status", rows[i][7:0], status_byte);
            chk("srq", {7'h0, |rows[i][7:0]}, {7'h0, srq_out});
            chk("err", (|rows[i][7:0]) ? 8'h00 : 8'h07, err_code);
            chk("done", 8'h01, {7'h0, cmd_done});
            chk("errv", {7'h0, ~|rows[i][7:0]}, {7'h0, err_valid});
            repeat (12) if (srq_out) @(negedge ref_clk);
            chk("cleared", 8'h00, status_byte);
            $display("row %0d done", i);
        end
        hold = 4'h8;
        {code_present, code_value} = 9'h105;
        cmd_exec = 1;
        @(negedge ref_clk);
        {code_present, code_value} = 9'h128;
        @(negedge ref_clk);
        cmd_exec = 0;
        chk("kept", 8'h45, status_byte);
        chk("err2", 8'h07, err_code);
        rst_n = 0;
        @(negedge ref_clk);
        chk("reset", 8'h00, status_byte);
        chk("reset srq", 8'h00, {7'h0, srq_out});
        rst_n = 1;
        {code_present, code_value} = 9'h107;
        cmd_exec = 1;
        @(negedge ref_clk);
        cmd_exec = 0;
        chk("after reset", 8'h47, status_byte);
        repeat (12) if (srq_out) @(negedge ref_clk);
        chk("cleared again", 8'h00, status_byte);
        $display("awkward cases done");
        wrap_up();
    end
endmodule : host_service_request_generator_tb
`default_nettype wire

// File: srq_gen_cfg.svh
// Constants for the host service request generator
`ifndef SRQ_GEN_CFG_SVH
`define SRQ_GEN_CFG_SVH

`define CODE_MAX        8'h1F
`define CODE_DEFAULT    5'h00
`define ERR_RANGE       8'h07
`define ERR_NONE        8'h00
`define STB_RQS_BIT     6
`define STB_CODE_W      5
`define STB_RESET       8'h00

`endif

// File: srq_gen_monitor.sv
// Checker for the service request generator
`timescale 1ns/10ps
`default_nettype none
module srq_gen_monitor (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       cmd_exec,
    input wire logic       code_present,
    input wire logic       poll_done,
    input wire logic       srq_out,
    input wire logic       cmd_done,
    input wire logic       err_valid,
    input wire logic [7:0] code_value,
    input wire logic [7:0] status_byte,
    input wire logic [7:0] err_code
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Command carrying an acceptable code
    sequence good; cmd_exec && (!code_present || code_value < 8'h20); endsequence
    chk_srq_raise: assert property (good |=> srq_out && cmd_done) else $error("no request");
    chk_poll_bit: assert property (good |=> status_byte[6]) else $error("bit 6 low");
    chk_code_low: assert property (good |=> {3'h0, status_byte[4:0]} ==
        ($past(code_present) ? $past(code_value) & 8'h1F : 8'h00)) else $error("bad code");
    chk_range_err: assert property (cmd_exec && code_present && code_value > 8'h1F
        |=> err_valid && err_code == 8'h07 && srq_out == $past(srq_out && !poll_done))
        else $error("no range error");
    chk_no_spur: assert property ($rose(srq_out) |-> $past(cmd_exec)) else $error("stray");
    chk_poll_clr: assert property (poll_done && srq_out && !cmd_exec
        |=> !srq_out && status_byte == 8'h00) else $error("poll kept request");
endmodule : srq_gen_monitor
bind host_service_request_generator srq_gen_monitor mon (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .cmd_exec     (cmd_exec),
    .code_present (code_present),
    .poll_done    (poll_done),
    .srq_out      (srq_out),
    .cmd_done     (cmd_done),
    .err_valid    (err_valid),
    .code_value   (code_value),
    .status_byte  (status_byte),
    .err_code     (err_code)
);
`default_nettype wire

// File: srq_gen_pkg.sv
// Types for the host service request generator
package srq_gen_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PENDING,
        ST_POLLED
    } srq_state_t;
endpackage : srq_gen_pkg
